// ---- dv/adc_ctrl_checker_sva.sv ----
// Assertion checker for the converter control ports
`timescale 1ns/1ps
module adc_ctrl_checker (
  input wire logic                      clk_sys_in,
  input wire logic                      reset_in,
  input wire adc_ctrl_pkg::reg_req_t    reg_req_in,
  input wire logic [7:0]                reg_rdata_out,
  input wire adc_ctrl_pkg::analog_ctl_t analog_ctl_out,
  input wire logic                      conv_done_irq_out,
  input wire logic                      busy_out
);
  import adc_ctrl_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_reset_idles: assert property (disable iff (1'b0) reset_in |=> !busy_out && !conv_done_irq_out)
    else $error("outputs active after reset");
  a_timing_bit6_zero: assert property ($past(reg_req_in.rd) && $past(reg_req_in.addr[2:0]) == OFS_TIMING_CONFIG
    |-> !reg_rdata_out[6]) else $error("timing bit 6 read as one");
  a_read_idle_zero: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_hold_open_strobe: assert property (analog_ctl_out.comp_strobe |-> !analog_ctl_out.sample_connect)
    else $error("hold connected during decision");
  a_strobe_needs_busy: assert property (analog_ctl_out.comp_strobe |-> busy_out)
    else $error("decision while not busy");
  a_strobe_single: assert property (analog_ctl_out.comp_strobe |=> !analog_ctl_out.comp_strobe)
    else $error("decision strobe longer than one clock");
  a_clear_start_aborts: assert property (reg_req_in.wr && reg_req_in.addr[2:0] == OFS_CONTROL_MAIN
    && !reg_req_in.wdata[POS_START_BUSY] |=> !busy_out) else $error("busy kept after start cleared");
  a_irq_off_clear: assert property (reg_req_in.wr && reg_req_in.addr[2:0] == OFS_IRQ_CTRL
    && reg_req_in.wdata == 8'h00 |=> !conv_done_irq_out) else $error("interrupt kept after disable");
  c_busy_rise: cover property ($rose(busy_out));
  c_irq_rise: cover property ($rose(conv_done_irq_out));
  c_strobe: cover property (analog_ctl_out.comp_strobe);
endmodule // adc_ctrl_checker

bind adc_acquisition_conversion_ctrl adc_ctrl_checker adc_ctrl_checker_inst (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
  .analog_ctl_out(analog_ctl_out), .conv_done_irq_out(conv_done_irq_out), .busy_out(busy_out));

// ---- dv/analog_front_model.sv ----
// Behavioural analog front end: hold capacitor and comparator
`timescale 1ns/1ps
module analog_front_model (
  input  wire logic                      clk_sys_in,
  input  wire logic [9:0]                level_in,
  input  wire adc_ctrl_pkg::analog_ctl_t analog_ctl_in,
  output logic                           comparator_out
);
  import adc_ctrl_pkg::*;
  logic [9:0] hold_ff = 10'h000;
  // Capacitor follows the pin only while connected
  always_ff @(posedge clk_sys_in) begin
    if (analog_ctl_in.sample_connect) begin
      hold_ff <= level_in;
    end
  end
  // Ideal comparator, so the result equals the held level
  assign comparator_out = (hold_ff >= analog_ctl_in.dac_code);
endmodule // analog_front_model

// ---- dv/tb_adc_acquisition_conversion_ctrl.sv ----
// Self-checking bench for the converter control
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_adc_acquisition_conversion_ctrl;
  import adc_ctrl_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        reset_in   = 1'b1;
  reg_req_t    req        = '0;
  logic        sleep_in   = 1'b0;
  logic [9:0]  level      = 10'h000;
  logic        comparator;
  logic [7:0]  rdata;
  analog_ctl_t actl;
  logic        irq;
  logic        busy;
  logic [7:0]  exp_hi;
  logic [7:0]  exp_lo;
  int          acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int          mismatches = 0;
  int          checked    = 0;
  int          cycles     = 0;

  adc_acquisition_conversion_ctrl adc_acquisition_conversion_ctrl_inst (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .reg_req_in(req), .comparator_in(comparator), .sleep_in(sleep_in),
    .reg_rdata_out(rdata), .analog_ctl_out(actl), .conv_done_irq_out(irq), .busy_out(busy));
  analog_front_model analog_front_model_inst (.clk_sys_in(clk_sys_in), .level_in(level),
    .analog_ctl_in(actl), .comparator_out(comparator));

  initial begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, about twice the nine thousand or so cycles the tests need
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_in) req <= '0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_in) req <= '0;
    #1 `CHK(rdata, e)
  endtask

  // Start one conversion, count busy cycles, then leave the rest gap
  task automatic conv(input logic [7:0] tcfg, output int n);
    wr(8'h02, tcfg);
    wr(8'h00, 8'h03);
    n = 0;
    #1;
    while (busy === 1'b1 && n < 3000) begin
      @(posedge clk_sys_in) #1 n++;
    end
    repeat (220) @(posedge clk_sys_in);
  endtask

  task automatic t_regs();
    rchk(8'h02, 8'h00);
    rchk(8'h00, 8'h00);
    wr(8'h02, 8'hff);
    rchk(8'h02, 8'hbf);
    wr(8'h01, 8'h35);
    #1 `CHK({actl.vref_minus_ext, actl.vref_plus_ext, actl.pin_config}, 6'h35)
    wr(8'h06, 8'hff);
    rchk(8'h06, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h15);
    #1 `CHK(actl.channel, 4'h5)
    wr(8'h00, 8'h01);
    $display("done: registers");
  endtask

  task automatic t_clock();
    int n;
    int lo;
    for (int c = 0; c < 8; c++) begin
      // Internal RC keeps running through sleep, adds one instruction cycle
      @(posedge clk_sys_in) sleep_in <= (c[1:0] == 2'b11);
      lo = (c[1:0] == 2'b11) ? 1104 : 11 * (2 << (2 * c[1:0] + c[2]));
      conv({5'h00, c[2:0]}, n);
      `CHK(n >= lo && n <= lo + 6, 1'b1)
    end
    @(posedge clk_sys_in) sleep_in <= 1'b0;
    $display("done: clock select");
  endtask

  task automatic t_acq();
    int n;
    for (int a = 0; a < 8; a++) begin
      conv({2'b00, a[2:0], 3'b100}, n);
      `CHK(n >= (acq_tab[a] + 11) * 4 && n <= (acq_tab[a] + 11) * 4 + 6, 1'b1)
    end
    $display("done: acquisition");
  endtask

  task automatic t_result(input logic j, input logic [9:0] v);
    int n;
    @(posedge clk_sys_in) level <= v;
    wr(8'h05, 8'h06);
    conv({j, 7'h02}, n);
    exp_hi = j ? {6'h00, v[9:8]} : v[9:2];
    exp_lo = j ? v[7:0] : {v[1:0], 6'h00};
    `CHK(irq, 1'b1)
    rchk(8'h00, 8'h01);
    rchk(8'h05, 8'h07);
    rchk(8'h03, exp_hi);
    rchk(8'h04, exp_lo);
    wr(8'h05, 8'h00);
    #1 `CHK(irq, 1'b0)
    $display("done: result");
  endtask

  task automatic t_abort();
    @(posedge clk_sys_in) sleep_in <= 1'b1;
    @(posedge clk_sys_in) level <= 10'h3c1;
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h03);
    repeat (60) @(posedge clk_sys_in);
    #1 `CHK(busy, 1'b1)
    `CHK(actl.sample_connect, 1'b0)
    wr(8'h00, 8'h01);
    #1 `CHK(busy, 1'b0)
    @(posedge clk_sys_in) sleep_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    #1 `CHK(actl.sample_connect, 1'b1)
    rchk(8'h03, exp_hi);
    rchk(8'h04, exp_lo);
    $display("done: abort");
  endtask

  task automatic t_reset();
    wr(8'h02, 8'h12);
    wr(8'h00, 8'h03);
    repeat (50) @(posedge clk_sys_in);
    reset_in <= 1'b1;
    @(posedge clk_sys_in) reset_in <= 1'b0;
    #1 `CHK(busy, 1'b0)
    rchk(8'h02, 8'h00);
    rchk(8'h00, 8'h00);
    rchk(8'h03, exp_hi);
    rchk(8'h04, exp_lo);
    $display("done: reset");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_regs();
    t_clock();
    t_acq();
    t_result(1'b1, 10'h2a5);
    t_result(1'b0, 10'h15a);
    t_abort();
    t_reset();
    end_of_test();
  end
endmodule // tb_adc_acquisition_conversion_ctrl

// ---- hdl/adc_acquisition_conversion_ctrl.sv ----
// Converter control: acquisition timing, bit clock, successive approximation, result registers
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - Bit 7 set right-justifies, clear left-justifies
// - Acquisition code gives 0..20 bit periods
// - Clock code selects divider or internal RC
// - RC source waits one instruction cycle first
// - Timing register bit 6 reads zero
// - Completion loads result, clears busy, sets flag
// - Reset clears registers, turns off, aborts
// - Result pair untouched by reset
// - Code zero: start stops sampling, converts immediately
// - Nonzero code: sample programmed periods, then convert
// - Sampling resumes after each conversion
// - Only busy bit shows acquisition or conversion
// - Two bit periods wait before next acquisition
// - Sleep operation only with internal RC clock
// - Successive approximation over 10 bit decisions
// - Hold capacitor disconnected while converting
// - Reference selectable supply rails or pins
// - Shared pins configurable analog or digital
// - All intervals counted in bit periods, except the RC start delay in clocks
// - Conversion takes eleven bit periods
// - Clearing busy aborts, result kept
// - On bit enables module, busy meaningful only then
module adc_acquisition_conversion_ctrl (
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_in,
  input  wire adc_ctrl_pkg::reg_req_t    reg_req_in,
  input  wire logic                      comparator_in,
  input  wire logic                      sleep_in,
  output logic [7:0]                     reg_rdata_out,
  output adc_ctrl_pkg::analog_ctl_t      analog_ctl_out,
  output logic                           conv_done_irq_out,
  output logic                           busy_out
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [7:0]  control_main;
    logic [7:0]  pin_reference;
    logic [7:0]  timing;
    logic [7:0]  result_high;
    logic [7:0]  result_low;
    logic        done_flag;
    logic        irq_en;
    logic        global_irq_en;
    phase_t      phase;
    logic [6:0]  div_cnt;
    logic [5:0]  rc_cnt;
    logic        bit_tick;
    logic [4:0]  period_cnt;
    logic [9:0]  sar;
    logic [9:0]  trial;
    logic [2:0]  comp_sync;
    logic        comp_level;
    // Sleep request comes from outside the clock domain
    logic [2:0]  sleep_sync;
    logic        sleep_level;
    logic [7:0]  rdata;
    analog_ctl_t ana;
    logic        irq;
    logic        busy;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  // Acquisition code to bit-period count
  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    case (code)
      3'h0:    acq_periods = 5'h00;
      3'h1:    acq_periods = 5'h02;
      3'h2:    acq_periods = 5'h04;
      3'h3:    acq_periods = 5'h06;
      3'h4:    acq_periods = 5'h08;
      3'h5:    acq_periods = 5'h0c;
      3'h6:    acq_periods = 5'h10;
      default: acq_periods = 5'h14;
    endcase
  endfunction

  // Half bit period in system clocks for divider codes
  function automatic logic [6:0] half_div(input logic [2:0] code);
    case (code)
      3'h0:    half_div = 7'h01;
      3'h1:    half_div = 7'h04;
      3'h2:    half_div = 7'h10;
      3'h4:    half_div = 7'h02;
      3'h5:    half_div = 7'h08;
      3'h6:    half_div = 7'h20;
      default: half_div = RC_HALF_CYCLES[6:0];
    endcase
  endfunction

  function automatic logic is_rc(input logic [2:0] code);
    is_rc = (code[1:0] == 2'h3);
  endfunction

  // Final bit tick of a conversion; load wins over a same-cycle abort
  function automatic logic last_conv_tick(input state_t s);
    last_conv_tick = s.phase == ST_CONVERT && s.bit_tick &&
                     s.period_cnt == CONV_BIT_PERIODS[4:0] - 5'h01;
  endfunction

  // Register read view; unmapped indices read zero
  function automatic logic [7:0] read_view(input state_t s, input logic [2:0] idx);
    case (idx)
      OFS_CONTROL_MAIN:   read_view = s.control_main;
      OFS_PIN_REF_CONFIG: read_view = s.pin_reference;
      OFS_TIMING_CONFIG:  read_view = s.timing & MASK_TIMING;
      OFS_RESULT_HIGH:    read_view = s.result_high;
      OFS_RESULT_LOW:     read_view = s.result_low;
      OFS_IRQ_CTRL:       read_view = {5'h00, s.global_irq_en, s.irq_en, s.done_flag};
      default:            read_view = 8'h00;
    endcase
  endfunction

  logic [2:0] acq_code;
  logic [2:0] clk_code;
  logic       on_bit;
  logic       start_bit;
  logic       run_clock;
  logic       stalled;
  logic [9:0] placed;
  logic [7:0] cm_write;

  always_comb begin
    nxt_cur   = cur_ff;
    acq_code  = cur_ff.timing[5:3];
    clk_code  = cur_ff.timing[2:0];
    on_bit    = cur_ff.control_main[POS_CONVERTER_ON];
    start_bit = cur_ff.control_main[POS_START_BUSY];
    cm_write  = reg_req_in.wdata & MASK_CONTROL_MAIN;
    placed    = cur_ff.sar;

    // Third stage agrees with second before a change counts
    nxt_cur.comp_sync = {cur_ff.comp_sync[1:0], comparator_in};
    if (cur_ff.comp_sync[2] == cur_ff.comp_sync[1]) begin
      nxt_cur.comp_level = cur_ff.comp_sync[2];
    end

    // Same three-stage filter for the sleep request
    nxt_cur.sleep_sync = {cur_ff.sleep_sync[1:0], sleep_in};
    if (cur_ff.sleep_sync[2] == cur_ff.sleep_sync[1]) begin
      nxt_cur.sleep_level = cur_ff.sleep_sync[2];
    end

    // Without the RC clock the core clock halts in sleep
    stalled   = cur_ff.sleep_level && !is_rc(clk_code);
    run_clock = on_bit && !stalled && cur_ff.phase != ST_SAMPLE && cur_ff.phase != ST_RC_DELAY;

    nxt_cur.bit_tick = 1'b0;
    if (!run_clock) begin
      nxt_cur.div_cnt = 7'h00;
    end else if (cur_ff.div_cnt >= (half_div(clk_code) << 1) - 7'h01) begin
      nxt_cur.div_cnt  = 7'h00;
      nxt_cur.bit_tick = 1'b1;
    end else begin
      nxt_cur.div_cnt = cur_ff.div_cnt + 7'h01;
    end

    // Register writes
    if (reg_req_in.wr) begin
      case (reg_req_in.addr[2:0])
        OFS_CONTROL_MAIN:   nxt_cur.control_main  = cm_write;
        OFS_PIN_REF_CONFIG: nxt_cur.pin_reference = reg_req_in.wdata & MASK_PIN_REF;
        OFS_TIMING_CONFIG:  nxt_cur.timing        = reg_req_in.wdata & MASK_TIMING;
        OFS_RESULT_HIGH:    nxt_cur.result_high   = reg_req_in.wdata;
        OFS_RESULT_LOW:     nxt_cur.result_low    = reg_req_in.wdata;
        OFS_IRQ_CTRL: begin
          nxt_cur.done_flag     = reg_req_in.wdata[POS_DONE_FLAG];
          nxt_cur.irq_en        = reg_req_in.wdata[POS_IRQ_EN];
          nxt_cur.global_irq_en = reg_req_in.wdata[POS_GLOBAL_IRQ_EN];
        end
        default: ;
      endcase
    end

    // Sequencer
    case (cur_ff.phase)
      ST_SAMPLE: begin
        // Starts once on and start bits are both set, even by one write; same-write enable plus start is a misuse
        if (on_bit && start_bit) begin
          nxt_cur.period_cnt = acq_periods(acq_code);
          nxt_cur.rc_cnt     = 6'h00;
          if (is_rc(clk_code)) begin
            nxt_cur.phase = ST_RC_DELAY;
          end else if (acq_code == 3'h0) begin
            nxt_cur.phase = ST_CONVERT;
            nxt_cur.period_cnt = 5'h00;
            nxt_cur.sar   = 10'h000;
            nxt_cur.trial = 10'h200;
          end else begin
            nxt_cur.phase = ST_ACQUIRE;
          end
        end
      end

      // One instruction cycle before the RC clock runs
      ST_RC_DELAY: begin
        if (cur_ff.rc_cnt >= INSTR_CYCLES[5:0] - 6'h01) begin
          nxt_cur.phase = (cur_ff.period_cnt == 5'h00) ? ST_CONVERT : ST_ACQUIRE;
          nxt_cur.sar   = 10'h000;
          nxt_cur.trial = 10'h200;
        end else begin
          nxt_cur.rc_cnt = cur_ff.rc_cnt + 6'h01;
        end
      end

      // Programmed sampling, counted down in bit periods
      ST_ACQUIRE: begin
        if (cur_ff.bit_tick) begin
          if (cur_ff.period_cnt <= 5'h01) begin
            nxt_cur.phase      = ST_CONVERT;
            nxt_cur.period_cnt = 5'h00;
            nxt_cur.sar        = 10'h000;
            nxt_cur.trial      = 10'h200;
          end else begin
            nxt_cur.period_cnt = cur_ff.period_cnt - 5'h01;
          end
        end
      end

      // Hold capacitor isolated, one decision per tick after the first
      ST_CONVERT: begin
        if (cur_ff.bit_tick) begin
          // First bit period settles, then one decision per period
          if (cur_ff.period_cnt != 5'h00 && cur_ff.comp_level) begin
            nxt_cur.sar = cur_ff.sar | cur_ff.trial;
          end
          if (cur_ff.period_cnt != 5'h00) begin
            nxt_cur.trial = cur_ff.trial >> 1;
          end
          nxt_cur.period_cnt = cur_ff.period_cnt + 5'h01;
          if (cur_ff.period_cnt == CONV_BIT_PERIODS[4:0] - 5'h01) begin
            nxt_cur.phase      = ST_WAIT;
            nxt_cur.period_cnt = 5'h00;
            nxt_cur.control_main[POS_START_BUSY] = 1'b0;
            nxt_cur.done_flag  = 1'b1;
          end
        end
      end

      // Gap before the next acquisition can start
      ST_WAIT: begin
        if (cur_ff.bit_tick) begin
          nxt_cur.period_cnt = cur_ff.period_cnt + 5'h01;
          if (cur_ff.period_cnt == WAIT_BIT_PERIODS[4:0] - 5'h01) begin
            nxt_cur.phase = ST_SAMPLE;
          end
        end
      end
      default: nxt_cur.phase = ST_SAMPLE;
    endcase

    // Result load on the final bit, justified per the format bit
    if (last_conv_tick(cur_ff)) begin
      placed = cur_ff.sar | ((cur_ff.comp_level) ? cur_ff.trial : 10'h000);
      if (cur_ff.timing[POS_JUSTIFY]) begin
        nxt_cur.result_high = {6'h00, placed[9:8]};
        nxt_cur.result_low  = placed[7:0];
      end else begin
        nxt_cur.result_high = placed[9:2];
        nxt_cur.result_low  = {placed[1:0], 6'h00};
      end
    end

    // Busy cleared by software or module off aborts; result untouched
    if ((cur_ff.phase == ST_ACQUIRE || cur_ff.phase == ST_CONVERT || cur_ff.phase == ST_RC_DELAY) &&
        (!nxt_cur.control_main[POS_START_BUSY] || !nxt_cur.control_main[POS_CONVERTER_ON]) &&
        !last_conv_tick(cur_ff)) begin
      nxt_cur.phase      = ST_WAIT;
      nxt_cur.period_cnt = 5'h00;
    end
    if (!nxt_cur.control_main[POS_CONVERTER_ON]) begin
      nxt_cur.phase = ST_SAMPLE;
    end

    // Read data, registered for the next cycle
    nxt_cur.rdata = 8'h00;
    if (reg_req_in.rd) begin
      nxt_cur.rdata = read_view(cur_ff, reg_req_in.addr[2:0]);
    end

    // Analog side
    nxt_cur.ana.sample_connect = on_bit && nxt_cur.phase != ST_CONVERT;
    // Gated on the next phase so an abort never leaves a stray strobe
    nxt_cur.ana.comp_strobe    = nxt_cur.bit_tick && nxt_cur.phase == ST_CONVERT;
    nxt_cur.ana.dac_code       = nxt_cur.sar | nxt_cur.trial;
    nxt_cur.ana.vref_plus_ext  = nxt_cur.pin_reference[4];
    nxt_cur.ana.vref_minus_ext = nxt_cur.pin_reference[5];
    nxt_cur.ana.channel        = nxt_cur.control_main[5:2];
    nxt_cur.ana.pin_config     = nxt_cur.pin_reference[3:0];
    nxt_cur.irq  = nxt_cur.done_flag && nxt_cur.irq_en && nxt_cur.global_irq_en;
    nxt_cur.busy = nxt_cur.control_main[POS_START_BUSY] && nxt_cur.control_main[POS_CONVERTER_ON];
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      // Result pair left alone: unknown after power-up
      cur_ff                 <= nxt_cur;
      cur_ff.control_main    <= RST_CONTROL_MAIN;
      cur_ff.pin_reference   <= RST_PIN_REF_CONFIG;
      cur_ff.timing          <= RST_TIMING_CONFIG;
      cur_ff.done_flag       <= 1'b0;
      cur_ff.irq_en          <= 1'b0;
      cur_ff.global_irq_en   <= 1'b0;
      cur_ff.phase           <= ST_SAMPLE;
      cur_ff.div_cnt         <= 7'h00;
      cur_ff.rc_cnt          <= 6'h00;
      cur_ff.bit_tick        <= 1'b0;
      cur_ff.period_cnt      <= 5'h00;
      cur_ff.sar             <= 10'h000;
      cur_ff.trial           <= 10'h000;
      cur_ff.comp_sync       <= 3'h0;
      cur_ff.comp_level      <= 1'b0;
      cur_ff.sleep_sync      <= 3'h0;
      cur_ff.sleep_level     <= 1'b0;
      cur_ff.rdata           <= 8'h00;
      cur_ff.ana             <= '0;
      cur_ff.irq             <= 1'b0;
      cur_ff.busy            <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign reg_rdata_out     = cur_ff.rdata;
  assign analog_ctl_out    = cur_ff.ana;
  assign conv_done_irq_out = cur_ff.irq;
  assign busy_out          = cur_ff.busy;

endmodule // adc_acquisition_conversion_ctrl

// ---- hdl/adc_ctrl_pkg.sv ----
// Package: register map, field layout and timing constants for the converter control
package adc_ctrl_pkg;

  localparam logic [2:0] OFS_CONTROL_MAIN   = 3'h0;
  localparam logic [2:0] OFS_PIN_REF_CONFIG = 3'h1;
  localparam logic [2:0] OFS_TIMING_CONFIG  = 3'h2;
  localparam logic [2:0] OFS_RESULT_HIGH    = 3'h3;
  localparam logic [2:0] OFS_RESULT_LOW     = 3'h4;
  localparam logic [2:0] OFS_IRQ_CTRL       = 3'h5;

  localparam int POS_CONVERTER_ON  = 0;
  localparam int POS_START_BUSY    = 1;
  localparam int POS_JUSTIFY       = 7;
  localparam int POS_DONE_FLAG     = 0;
  localparam int POS_IRQ_EN        = 1;
  localparam int POS_GLOBAL_IRQ_EN = 2;

  localparam logic [7:0] RST_CONTROL_MAIN   = 8'h00;
  localparam logic [7:0] RST_PIN_REF_CONFIG = 8'h00;
  localparam logic [7:0] RST_TIMING_CONFIG  = 8'h00;
  localparam logic [7:0] MASK_CONTROL_MAIN  = 8'hbf;
  localparam logic [7:0] MASK_PIN_REF       = 8'h3f;
  localparam logic [7:0] MASK_TIMING        = 8'hbf;

  localparam int RESULT_BITS       = 10;
  localparam int CONV_BIT_PERIODS  = 11;
  localparam int WAIT_BIT_PERIODS  = 2;
  // Internal RC bit period as printed, and one instruction cycle of four clocks
  localparam int RC_PERIOD_NS      = 4000;
  localparam int CLK_PERIOD_NS     = 40;
  localparam int RC_HALF_CYCLES    = RC_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam int INSTR_CYCLES      = 4;

  typedef enum logic [2:0] {ST_SAMPLE, ST_RC_DELAY, ST_ACQUIRE, ST_CONVERT, ST_WAIT} phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       sample_connect;
    logic       comp_strobe;
    logic [9:0] dac_code;
    logic       vref_plus_ext;
    logic       vref_minus_ext;
    logic [3:0] channel;
    logic [3:0] pin_config;
  } analog_ctl_t;

endpackage : adc_ctrl_pkg
